// ==== logic/dps_host.sv ====
// Host sequencer: program, sector erase, ID exit and status polling
`timescale 1ns/1ps
`default_nettype none
module dps_host
  import dps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        req_valid,
  input  wire dps_req_t    req,
  output logic             req_ready,
  output logic             resp_valid,
  output logic [15:0]      resp_data,
  input  wire logic [15:0] flash_dq_in,
  output dps_pins_t        flash
);
  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_SEQ  = 4'b0010,
    M_POLL = 4'b0100,
    M_READ = 4'b1000
  } dps_mstate_t;

  dps_mstate_t state, next_state;
  dps_req_t    req_q, next_req_q;
  logic [2:0]  step, next_step;
  logic        first, next_first;
  logic        last_tog, next_last_tog;
  logic        cyc_start, next_cyc_start;
  dps_cyc_t    cyc, next_cyc;
  logic        next_req_ready;
  logic        next_resp_valid;
  logic [15:0] next_resp_data;
  logic        cyc_done;
  logic [15:0] cyc_rdata;

  function automatic logic [2:0] last_step(input dps_op_t op);
    unique case (op)
      OP_PROGRAM: last_step = PROGRAM_LAST;
      OP_ERASE:   last_step = ERASE_LAST;
      default:    last_step = ID_EXIT_LAST;
    endcase
  endfunction : last_step

  // Write cycle for one step of a command sequence
  function automatic dps_cyc_t seq_cycle(input dps_req_t r,
                                         input logic [2:0] s);
    dps_cyc_t c;
    c.write = 1'b1;
    c.gap   = WRITE_GAP_CYC;
    c.addr  = UNLOCK1_ADDR;
    c.data  = UNLOCK1_DATA;
    unique case (s)
      3'h1, 3'h4: begin
        c.addr = UNLOCK2_ADDR;
        c.data = UNLOCK2_DATA;
      end
      3'h2: begin
        unique case (r.op)
          OP_PROGRAM: c.data = CMD_PROGRAM;
          OP_ERASE:   c.data = CMD_ERASE_SETUP;
          default:    c.data = CMD_ID_EXIT;
        endcase
      end
      3'h3: begin
        if (r.op == OP_PROGRAM) begin
          c.addr = r.addr;
          c.data = r.data;
        end
      end
      3'h5: begin
        c.addr = r.addr;
        c.data = CMD_SECTOR_ERASE;
      end
      default: ;
    endcase
    if (s == ERASE_GAP_STEP) begin
      c.gap = ERASE_GAP_CYC;
    end
    return c;
  endfunction : seq_cycle

  // Poll read: same address each time, long strobe-high gap
  function automatic dps_cyc_t poll_cycle(input logic [19:0] a);
    dps_cyc_t c;
    c.write = 1'b0;
    c.addr  = a;
    c.data  = 16'h0000;
    c.gap   = READ_GAP_CYC;
    return c;
  endfunction : poll_cycle

  always_comb begin
    next_state      = state;
    next_req_q      = req_q;
    next_step       = step;
    next_first      = first;
    next_last_tog   = last_tog;
    next_cyc_start  = 1'b0;
    next_cyc        = cyc;
    next_resp_valid = 1'b0;
    next_resp_data  = resp_data;
    unique case (state)
      M_IDLE: if (req_valid && req_ready) begin
        next_req_q     = req;
        next_step      = 3'h0;
        next_cyc_start = 1'b1;
        if (req.op == OP_READ) begin
          next_state = M_READ;
          next_cyc   = poll_cycle(req.addr);
        end else begin
          next_state = M_SEQ;
          next_cyc   = seq_cycle(req, 3'h0);
        end
      end
      M_SEQ: if (cyc_done) begin
        next_cyc_start = 1'b1;
        if (step != last_step(req_q.op)) begin
          next_step = step + 3'h1;
          next_cyc  = seq_cycle(req_q, step + 3'h1);
        end else if (req_q.op == OP_ID_EXIT) begin
          next_cyc_start  = 1'b0;
          next_state      = M_IDLE;
          next_resp_valid = 1'b1;
          next_resp_data  = 16'h0000;
        end else begin
          next_state = M_POLL;
          next_first = 1'b1;
          next_cyc   = poll_cycle(req_q.addr);
        end
      end
      M_POLL: if (cyc_done) begin
        // No fixed wait: poll until two reads agree on the toggle bit
        if (!first && cyc_rdata[TOGGLE_BIT] == last_tog) begin
          next_state      = M_IDLE;
          next_resp_valid = 1'b1;
          next_resp_data  = cyc_rdata;
        end else begin
          next_first     = 1'b0;
          next_last_tog  = cyc_rdata[TOGGLE_BIT];
          next_cyc_start = 1'b1;
        end
      end
      M_READ: if (cyc_done) begin
        next_state      = M_IDLE;
        next_resp_valid = 1'b1;
        next_resp_data  = cyc_rdata;
      end
    endcase
    next_req_ready = (next_state == M_IDLE);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state      <= M_IDLE;
      req_q      <= '{op: OP_READ, addr: 20'h00000, data: 16'h0000};
      step       <= 3'h0;
      first      <= 1'b1;
      last_tog   <= 1'b0;
      cyc_start  <= 1'b0;
      cyc        <= '{write: 1'b0, addr: 20'h00000, data: 16'h0000,
                      gap: 4'h0};
      req_ready  <= 1'b1;
      resp_valid <= 1'b0;
      resp_data  <= 16'h0000;
    end else begin
      state      <= next_state;
      req_q      <= next_req_q;
      step       <= next_step;
      first      <= next_first;
      last_tog   <= next_last_tog;
      cyc_start  <= next_cyc_start;
      cyc        <= next_cyc;
      req_ready  <= next_req_ready;
      resp_valid <= next_resp_valid;
      resp_data  <= next_resp_data;
    end
  end

  dps_bus_cycle u_bus (
    .clk   (clk),
    .nrst  (nrst),
    .start (cyc_start),
    .cyc   (cyc),
    .dq_in (flash_dq_in),
    .done  (cyc_done),
    .rdata (cyc_rdata),
    .pins  (flash)
  );

  // Helper state for the checks below
  logic       we_q;
  logic [2:0] wr_cnt;
  logic       tog_h1, tog_h2;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      we_q   <= 1'b1;
      wr_cnt <= 3'h0;
      tog_h1 <= 1'b0;
      tog_h2 <= 1'b0;
    end else begin
      we_q <= flash.we_n;
      if (state == M_IDLE) begin
        wr_cnt <= 3'h0;
      end else if (we_q && !flash.we_n) begin
        wr_cnt <= wr_cnt + 3'h1;
      end
      if (state == M_POLL && cyc_done) begin
        tog_h1 <= cyc_rdata[TOGGLE_BIT];
        tog_h2 <= tog_h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_fifth_we_rise;
    $rose(flash.we_n) && req_q.op == OP_ERASE && wr_cnt == 3'h5;
  endsequence
  sequence s_we_high3;
    flash.we_n [*3];
  endsequence
  sequence s_sixth_we_fall;
    $fell(flash.we_n) && req_q.op == OP_ERASE && wr_cnt == 3'h5;
  endsequence

  a_poll_addr_fixed: assert property (
    state == M_POLL && !flash.ce_n |-> flash.addr == req_q.addr)
    else $error("poll read address changed");
  a_toggle_compare: assert property (
    resp_valid && (req_q.op == OP_PROGRAM || req_q.op == OP_ERASE)
    |-> tog_h1 == tog_h2 && resp_data[TOGGLE_BIT] == tog_h1)
    else $error("completion without two equal toggle reads");
  a_read_oe_gap: assert property (
    $rose(flash.oe_n) |-> flash.oe_n [*3])
    else $error("output enable high gap too short");
  a_read_ce_gap: assert property (
    $rose(flash.ce_n) && state == M_POLL |-> flash.ce_n [*3])
    else $error("chip enable high gap too short while polling");
  a_erase_gap_wait: assert property (
    s_fifth_we_rise |-> s_we_high3)
    else $error("write gap before sixth erase write too short");
  a_erase_sector_addr: assert property (
    s_sixth_we_fall |-> flash.addr == req_q.addr
      && flash.dq_out == CMD_SECTOR_ERASE && !flash.dq_oe_n)
    else $error("sixth erase write lacks sector address");
  a_write_low_width: assert property (
    $fell(flash.we_n) |-> !flash.we_n [*2])
    else $error("write strobe low too short");
  a_poll_follows_seq: assert property (
    state == M_SEQ && cyc_done && step == ERASE_LAST
      && req_q.op == OP_ERASE |=> state == M_POLL ##2 !flash.ce_n)
    else $error("erase not followed by polling");
endmodule : dps_host
`default_nettype wire

// ==== logic/dps_pkg.sv ====
// Constants, types and command codes for the flash status-polling host
`default_nettype none
package dps_pkg;
  // Clock and pin timing, in ns as specified
  localparam int CLK_PERIOD_NS       = 50;
  localparam int WRITE_LOW_NS        = 100;
  localparam int WRITE_HIGH_GAP_NS   = 50;
  localparam int ERASE_GAP_NS        = 150;
  localparam int READ_STROBE_HIGH_NS = 150;
  localparam int READ_ACCESS_NS      = 90;
  // Pin to agreed-value latency of the three-stage input synchroniser
  localparam int SYNC_LAT_CYC        = 4;

  // Least times rounded up to whole clock cycles; the read strobe also adds SYNC_LAT_CYC
  localparam logic [3:0] WRITE_LOW_CYC =
    4'((WRITE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WRITE_GAP_CYC =
    4'((WRITE_HIGH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] ERASE_GAP_CYC =
    4'((ERASE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] READ_GAP_CYC =
    4'((READ_STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] READ_LOW_CYC =
    4'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT_CYC);

  // Status bit positions on the data bus
  localparam int POLL_BIT          = 7;
  localparam int TOGGLE_BIT        = 6;
  localparam int SECTOR_TOGGLE_BIT = 2;

  // Command cycle addresses and data
  localparam logic [19:0] UNLOCK1_ADDR     = 20'h05555;
  localparam logic [19:0] UNLOCK2_ADDR     = 20'h02AAA;
  localparam logic [15:0] UNLOCK1_DATA     = 16'h00AA;
  localparam logic [15:0] UNLOCK2_DATA     = 16'h0055;
  localparam logic [15:0] CMD_PROGRAM      = 16'h00A0;
  localparam logic [15:0] CMD_ERASE_SETUP  = 16'h0080;
  localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [15:0] CMD_ID_EXIT      = 16'h00F0;

  // Last write step of each sequence, and the erase step followed by the long gap
  localparam logic [2:0] PROGRAM_LAST = 3'h3;
  localparam logic [2:0] ERASE_LAST   = 3'h5;
  localparam logic [2:0] ID_EXIT_LAST = 3'h2;
  localparam logic [2:0] ERASE_GAP_STEP = 3'h4;

  typedef enum logic [1:0] {
    OP_READ    = 2'h0,
    OP_PROGRAM = 2'h1,
    OP_ERASE   = 2'h2,
    OP_ID_EXIT = 2'h3
  } dps_op_t;

  typedef struct packed {
    dps_op_t     op;
    logic [19:0] addr;
    logic [15:0] data;
  } dps_req_t;

  typedef struct packed {
    logic        write;
    logic [19:0] addr;
    logic [15:0] data;
    logic [3:0]  gap;
  } dps_cyc_t;

  typedef struct packed {
    logic [19:0] addr;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [15:0] dq_out;
    logic        dq_oe_n;
  } dps_pins_t;
endpackage : dps_pkg
`default_nettype wire

// ==== logic/dps_bus_cycle.sv ====
// One timed flash bus cycle (write or read) with synchronised data input
`timescale 1ns/1ps
`default_nettype none
module dps_bus_cycle
  import dps_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      nrst,
  input  wire logic      start,
  input  wire dps_cyc_t  cyc,
  input  wire logic [15:0] dq_in,
  output logic           done,
  output logic [15:0]    rdata,
  output dps_pins_t      pins
);
  typedef enum logic [3:0] {
    B_IDLE    = 4'b0001,
    B_SETUP   = 4'b0010,
    B_STROBE  = 4'b0100,
    B_RECOVER = 4'b1000
  } dps_bstate_t;

  dps_bstate_t state, next_state;
  logic [3:0]  cnt, next_cnt;
  logic        write, next_write;
  logic [3:0]  gap, next_gap;
  logic        next_done;
  logic [15:0] next_rdata;
  dps_pins_t   next_pins;
  logic [15:0] dq_s1, dq_s2, dq_s3, dq_agreed, next_agreed;

  // Value counts once the second and third stages agree
  always_comb begin
    next_agreed = (dq_s2 == dq_s3) ? dq_s3 : dq_agreed;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dq_s1     <= 16'h0000;
      dq_s2     <= 16'h0000;
      dq_s3     <= 16'h0000;
      dq_agreed <= 16'h0000;
    end else begin
      dq_s1     <= dq_in;
      dq_s2     <= dq_s1;
      dq_s3     <= dq_s2;
      dq_agreed <= next_agreed;
    end
  end

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_write = write;
    next_gap   = gap;
    next_done  = 1'b0;
    next_rdata = rdata;
    next_pins  = pins;
    unique case (state)
      B_IDLE: if (start) begin
        next_state        = B_SETUP;
        next_write        = cyc.write;
        next_gap          = cyc.gap;
        next_pins.addr    = cyc.addr;
        next_pins.dq_out  = cyc.data;
        next_pins.ce_n    = 1'b0;
        next_pins.dq_oe_n = !cyc.write;
      end
      B_SETUP: begin
        next_state = B_STROBE;
        next_cnt   = write ? WRITE_LOW_CYC : READ_LOW_CYC;
        if (write) begin
          next_pins.we_n = 1'b0;
        end else begin
          next_pins.oe_n = 1'b0;
        end
      end
      B_STROBE: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_state     = B_RECOVER;
          next_cnt       = gap;
          next_pins.we_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_pins.ce_n = 1'b1;
          if (!write) begin
            next_rdata = dq_agreed;
          end
        end
      end
      B_RECOVER: begin
        // Strobes stay high for the requested gap; write data still driven
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_state        = B_IDLE;
          next_done         = 1'b1;
          next_pins.dq_oe_n = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= B_IDLE;
      cnt   <= 4'h0;
      write <= 1'b0;
      gap   <= 4'h0;
      done  <= 1'b0;
      rdata <= 16'h0000;
      pins  <= '{addr: 20'h00000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                 dq_out: 16'h0000, dq_oe_n: 1'b1};
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      write <= next_write;
      gap   <= next_gap;
      done  <= next_done;
      rdata <= next_rdata;
      pins  <= next_pins;
    end
  end
endmodule : dps_bus_cycle
`default_nettype wire

// ==== tb/dps_flash_model.sv ====
// Behavioural dual-plane flash with status reporting and host checks
`timescale 1ns/1ps
`default_nettype none
module dps_flash_model
  import dps_pkg::*;
#(
  parameter int          PROG_NS  = 10000,
  parameter int          ERASE_NS = 50000,
  parameter logic [15:0] ID_CODE  = 16'h005D  // Arbitrary value
)(
  input  wire dps_pins_t pins,
  output logic [15:0]    dq,
  output var int         viol,
  output var int         busy_reads
);
  logic [15:0] mem [logic [19:0]];
  logic [35:0] hist [6];
  logic [15:0] rd_val, last, busy_data, v;
  logic [19:0] busy_addr, poll_addr, a, m, susp_addr;
  logic [19:0] q [$];
  logic        id_mode, tog, erasing, polled, rstb, wstb, susp;
  time         busy_end, t_rrise, t_wrise;

  assign rstb = pins.oe_n | pins.ce_n;
  assign wstb = pins.we_n | pins.ce_n;
  // Released bus shows the inverse of the last value
  assign dq = rstb ? ~last : rd_val;

  initial begin
    foreach (hist[i]) hist[i] = '0;
    {viol, busy_reads, busy_end, t_rrise} = '0;
    {id_mode, erasing, polled, susp} = '0;
    susp_addr = '0;
    tog = 1'b1;
    rd_val = 16'hA5C3;
    last = 16'hA5C3;
  end

  function automatic logic hm(int i, logic [19:0] ad, logic [15:0] d);
    return hist[i] == {ad, d};
  endfunction

  function automatic logic pre(int o);
    return hm(o + 4, UNLOCK1_ADDR, UNLOCK1_DATA) &&
           hm(o + 3, UNLOCK2_ADDR, UNLOCK2_DATA) &&
           hm(o + 2, UNLOCK1_ADDR, CMD_ERASE_SETUP) &&
           hm(o + 1, UNLOCK1_ADDR, UNLOCK1_DATA) &&
           hm(o, UNLOCK2_ADDR, UNLOCK2_DATA);
  endfunction

  function automatic logic [19:0] smask(logic [19:0] ad);
    if (ad >= 20'hF8000) return 20'hFF000;
    if (ad >= 20'hF0000) return 20'hFC000;
    return 20'hF8000;
  endfunction

  task automatic begin_op(logic [15:0] d, int ns, logic er);
    busy_addr = a;
    busy_data = d;
    erasing = er;
    polled = 1'b0;
    busy_end = $time + ns;
    foreach (hist[i]) hist[i] = '0;
  endtask

  always @(negedge wstb) begin
    if (pre(0) && $time - t_wrise < 150) viol++;
  end

  always @(posedge wstb) begin
    t_wrise = $time;
    if (pins.oe_n === 1'b1 && pins.dq_oe_n === 1'b0) begin
      for (int i = 5; i > 0; i--) hist[i] = hist[i-1];
      hist[0] = {pins.addr, pins.dq_out};
      a = pins.addr;
      if (hist[0][15:0] == CMD_ID_EXIT) id_mode = 1'b0;
      if (hm(3, UNLOCK1_ADDR, UNLOCK1_DATA) &&
          hm(2, UNLOCK2_ADDR, UNLOCK2_DATA) &&
          hm(1, UNLOCK1_ADDR, CMD_PROGRAM)) begin
        mem[a] = pins.dq_out;
        begin_op(pins.dq_out, PROG_NS, 1'b0);
      end else if (pre(1) && pins.dq_out == CMD_SECTOR_ERASE) begin
        m = smask(a);
        q.delete();
        foreach (mem[k]) if ((k & m) == (a & m)) q.push_back(k);
        foreach (q[i]) mem.delete(q[i]);
        begin_op(16'hFFFF, ERASE_NS, 1'b1);
      end
    end
  end

  always @(negedge rstb) begin
    if (pins.we_n === 1'b1) begin
      a = pins.addr;
      v = mem.exists(a) ? mem[a] : 16'hFFFF;
      if ($time - t_rrise < 150) viol++;
      if (id_mode) begin
        v = ID_CODE;
      end else if (susp && ((a ^ susp_addr) & smask(susp_addr)) ==
                   20'h00000) begin
        // Sector with a suspended erase reports fixed poll and toggle bits; sector toggle bit alternates
        v[POLL_BIT] = 1'b1;
        v[TOGGLE_BIT] = 1'b1;
        v[SECTOR_TOGGLE_BIT] = tog;
      end else if ($time < busy_end && (a >= 20'hC0000) ==
                   (busy_addr >= 20'hC0000)) begin
        busy_reads++;
        if (polled && a != poll_addr) viol++;
        polled = 1'b1;
        poll_addr = a;
        v[POLL_BIT] = erasing ? 1'b0 : ~busy_data[POLL_BIT];
        v[TOGGLE_BIT] = tog;
        v[SECTOR_TOGGLE_BIT] = erasing ? tog : 1'b1;
      end
      rd_val = v;
    end
  end

  always @(posedge rstb) begin
    t_rrise = $time;
    last = rd_val;
    if ($time < busy_end || susp) tog = ~tog;
  end
endmodule : dps_flash_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the flash status-polling host
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dps_pkg::*;
  localparam int          ERASE_NS = 50000;
  localparam logic [15:0] ID_CODE  = 16'h005D;  // Arbitrary value
  logic        clk, nrst, req_valid, req_ready, resp_valid;
  dps_req_t    req;
  logic [15:0] resp_data, dq_in, model_dq, rd;
  logic        r1;
  dps_pins_t   flash;
  int          error_cnt, total_checks, viol, busy_reads, b0;
  time         dt;

  assign dq_in = flash.dq_oe_n ? model_dq : flash.dq_out;

  dps_host dps_host_i (
    .clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_data(resp_data), .flash_dq_in(dq_in), .flash(flash));

  dps_flash_model #(.ERASE_NS(ERASE_NS), .ID_CODE(ID_CODE))
    dps_flash_model_i (.pins(flash), .dq(model_dq), .viol(viol),
                       .busy_reads(busy_reads));

  always #25 clk = ~clk;

  task automatic summarize;
    $display("Checks: %0d, errors: %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tmo;
    error_cnt++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    summarize();
  endtask : tmo

  task automatic do_op(input dps_op_t op, input logic [19:0] a,
                       input logic [15:0] d);
    time t0;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{op, a, d};
    for (int n = 0; req_ready !== 1'b1; n++) begin
      if (n == 50) tmo();
      @(negedge clk);
    end
    @(posedge clk);
    t0 = $time;
    @(negedge clk);
    req_valid = 1'b0;
    chk(req_ready, 0);
    for (int n = 0; resp_valid !== 1'b1; n++) begin
      if (n == 5000) tmo();
      @(negedge clk);
    end
    rd = resp_data;
    dt = $time - t0;
  endtask : do_op

  task automatic t_reset;
    chk(req_ready, 1);
    chk(resp_valid, 0);
    chk(resp_data, 0);
    chk({flash.ce_n, flash.oe_n, flash.we_n, flash.dq_oe_n}, 4'hF);
  endtask : t_reset

  task automatic t_program;
    b0 = busy_reads;
    do_op(OP_PROGRAM, 20'h01234, 16'h5A3C);
    chk(rd, 16'h5A3C);
    chk(busy_reads > b0 + 1, 1);
    do_op(OP_PROGRAM, 20'hF9010, 16'h00A5);
    chk(rd, 16'h00A5);
    do_op(OP_READ, 20'h01234, 16'h0000);
    chk(rd, 16'h5A3C);
  endtask : t_program

  task automatic t_erase;
    do_op(OP_PROGRAM, 20'h10008, 16'h1234);
    do_op(OP_PROGRAM, 20'h18000, 16'h4321);
    do_op(OP_ERASE, 20'h10100, 16'h0000);
    chk(rd, 16'hFFFF);
    chk(dt >= ERASE_NS, 1);
    do_op(OP_READ, 20'h10008, 16'h0000);
    chk(rd, 16'hFFFF);
    do_op(OP_READ, 20'h18000, 16'h0000);
    chk(rd, 16'h4321);
    do_op(OP_READ, 20'hF9010, 16'h0000);
    chk(rd, 16'h00A5);
  endtask : t_erase

  task automatic t_suspend;
    dps_flash_model_i.susp_addr = 20'h18000;
    dps_flash_model_i.susp = 1'b1;
    do_op(OP_READ, 20'h18000, 16'h0000);
    chk(rd & 16'hFF3B, 16'h4321 & 16'hFF3B);
    chk(rd[POLL_BIT], 1);
    chk(rd[TOGGLE_BIT], 1);
    r1 = rd[SECTOR_TOGGLE_BIT];
    do_op(OP_READ, 20'h18000, 16'h0000);
    chk(rd[SECTOR_TOGGLE_BIT] ^ r1, 1);
    do_op(OP_READ, 20'hF9010, 16'h0000);
    chk(rd, 16'h00A5);
    dps_flash_model_i.susp = 1'b0;
  endtask : t_suspend

  task automatic t_id_exit;
    dps_flash_model_i.id_mode = 1'b1;
    do_op(OP_READ, 20'h00000, 16'h0000);
    chk(rd, ID_CODE);
    do_op(OP_ID_EXIT, 20'h00000, 16'h0000);
    chk(rd, 16'h0000);
    do_op(OP_READ, 20'h01234, 16'h0000);
    chk(rd, 16'h5A3C);
  endtask : t_id_exit

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    error_cnt = 0;
    total_checks = 0;
    repeat (20) @(negedge clk);
    t_reset();
    nrst = 1'b1;
    t_program();
    t_erase();
    t_suspend();
    t_id_exit();
    chk(viol, 0);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
